//--- rtl/rfhr_pkg.sv
/*
 * Constants, field positions and state encodings for receive frame header reporting.
 * Assumes one core clock and a host register port that reads 16-bit words by byte lanes.
 */
package rfhr_pkg;
    // register offsets
    localparam logic [8:0] RFHR_OFS_STATUS = 9'h17C;
    localparam logic [8:0] RFHR_OFS_COUNT = 9'h17E;
    // status word field positions
    localparam int RFHR_BIT_VALID = 15;
    localparam int RFHR_BIT_ICMP = 13;
    localparam int RFHR_BIT_IP = 12;
    localparam int RFHR_BIT_TCP = 11;
    localparam int RFHR_BIT_UDP = 10;
    localparam int RFHR_BIT_BCAST = 7;
    localparam int RFHR_BIT_MCAST = 6;
    localparam int RFHR_BIT_UCAST = 5;
    localparam int RFHR_BIT_FTYPE = 3;
    localparam int RFHR_BIT_RUNT = 1;
    localparam int RFHR_BIT_CRC = 0;
    // widths and thresholds
    localparam int RFHR_COUNT_W = 12;
    localparam int RFHR_ENTRY_W = 16 + RFHR_COUNT_W;
    localparam logic [15:0] RFHR_MAX_LENGTH = 16'h05DC;
    localparam logic [47:0] RFHR_BCAST_ADDR = 48'hFFFFFFFFFFFF;
    localparam logic [15:0] RFHR_WORD_RESET = 16'h0000;
    // head-of-queue presentation states
    typedef enum logic [2:0] {
        RFHR_EMPTY = 3'b001,
        RFHR_FETCH = 3'b010,
        RFHR_SHOW = 3'b100
    } rfhr_state_type;
endpackage : rfhr_pkg

//--- rtl/rfhr_mem_if.sv
/*
 * Carrier between the header reporting core and its header memory.
 * Assumes both ends sit on the same clock.
 */
interface rfhr_mem_if #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 28
);
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;

    modport core (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : rfhr_mem_if

//--- rtl/rfhr_hdr_mem.sv
/*
 * Small header memory, one entry per queued frame, registered read data.
 * Assumes one write port and one read port on the core clock.
 */
module rfhr_hdr_mem #(
    parameter int DEPTH = 16
) (
    // clock
    input wire logic clk_in,
    // memory port
    rfhr_mem_if.mem mem_bus
);
    logic [$bits(mem_bus.wr_data)-1:0] store [DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // write then registered read; no reset so it maps onto ram cells
    always_ff @(posedge clk_in) begin
        if (mem_bus.wr_en) begin
            store[mem_bus.wr_addr] <= mem_bus.wr_data;
        end
        mem_bus.rd_data <= store[mem_bus.rd_addr];
    end
endmodule : rfhr_hdr_mem

//--- rtl/rfhr_core.sv
/*
 * Receive frame header reporting: queues per-frame status and byte count, and
 * presents the head frame in two read-only 16-bit registers.
 * Assumes the receive path pulses frame_done_in once per finished frame with its
 * fields stable, and the queue manager pulses next_frame_in to release the head.
 */
module rfhr_core #(
    parameter int DEPTH = 16,
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // receive path, one pulse per finished frame
    input wire logic frame_done_in,
    input wire logic [47:0] dest_addr_in,
    input wire logic [15:0] length_type_in,
    input wire logic [rfhr_pkg::RFHR_COUNT_W-1:0] byte_count_in,
    input wire logic runt_in,
    input wire logic crc_error_in,
    input wire logic icmp_bad_in,
    input wire logic ip_bad_in,
    input wire logic tcp_bad_in,
    input wire logic udp_bad_in,
    input wire logic pass_bad_frames_in,
    // queue manager
    input wire logic next_frame_in,
    output logic [ADDR_W:0] frames_queued_out,
    output logic overflow_out,
    // host register read port
    input wire logic reg_rd_in,
    input wire logic [8:0] reg_addr_in,
    input wire logic [1:0] reg_be_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out
);
    import rfhr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // classifies the destination and frame type into the status word
    function automatic logic [15:0] build_status(
        input logic [47:0] dest,
        input logic [15:0] len_type,
        input logic runt,
        input logic crc,
        input logic icmp,
        input logic ip,
        input logic tcp,
        input logic udp
    );
        logic [15:0] word;
        logic bcast;
        logic mcast;
        word = RFHR_WORD_RESET;
        bcast = (dest == RFHR_BCAST_ADDR);
        // group bit is the lsb of the first octet sent, bits 47:40 here
        mcast = dest[40];
        word[RFHR_BIT_ICMP] = icmp;
        word[RFHR_BIT_IP] = ip;
        word[RFHR_BIT_TCP] = tcp;
        word[RFHR_BIT_UDP] = udp;
        word[RFHR_BIT_BCAST] = bcast;
        word[RFHR_BIT_MCAST] = mcast | bcast;
        word[RFHR_BIT_UCAST] = ~mcast;
        word[RFHR_BIT_FTYPE] = (len_type > RFHR_MAX_LENGTH);
        word[RFHR_BIT_RUNT] = runt;
        word[RFHR_BIT_CRC] = crc;
        return word;
    endfunction : build_status

    // pointer step with wrap at the queue depth
    function automatic logic [ADDR_W-1:0] step_ptr(input logic [ADDR_W-1:0] ptr);
        logic [ADDR_W-1:0] last;
        last = ADDR_W'(DEPTH - 1);
        return (ptr == last) ? '0 : ptr + 1'b1;
    endfunction : step_ptr

    ////////////////////////////////////////////////////////////////////////////////
    // state

    rfhr_state_type state;
    rfhr_state_type next_state;
    logic [ADDR_W-1:0] wr_ptr;
    logic [ADDR_W-1:0] rd_ptr;
    logic [ADDR_W:0] used;
    logic [15:0] status_view;
    logic [RFHR_COUNT_W-1:0] count_view;
    logic [7:0] count_hi_hold;

    rfhr_mem_if #(.ADDR_W(ADDR_W), .DATA_W(RFHR_ENTRY_W)) mem_bus ();

    rfhr_hdr_mem #(.DEPTH(DEPTH)) u_mem (
        .clk_in(clk_in),
        .mem_bus(mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // frame admission

    wire logic bad_frame = runt_in | crc_error_in;
    // bad frames are dropped here unless the host asked to see them
    wire logic admit = frame_done_in & (~bad_frame | pass_bad_frames_in);
    wire logic full = (used == (ADDR_W + 1)'(DEPTH));
    wire logic push = admit & ~full;
    wire logic pop = (state == RFHR_SHOW) & next_frame_in;
    wire logic [15:0] new_status = build_status(dest_addr_in, length_type_in, runt_in,
        crc_error_in, icmp_bad_in, ip_bad_in, tcp_bad_in, udp_bad_in);

    // one entry per frame pairs its status with its count
    assign mem_bus.wr_en = push;
    assign mem_bus.wr_addr = wr_ptr;
    assign mem_bus.wr_data = {new_status, byte_count_in};
    assign mem_bus.rd_addr = rd_ptr;

    ////////////////////////////////////////////////////////////////////////////////
    // head presentation sequence

    // the memory read takes one cycle, so a fresh head is fetched before it is shown
    always_comb begin
        next_state = state;
        unique case (state)
            RFHR_EMPTY: begin
                if (used != '0) begin
                    next_state = RFHR_FETCH;
                end
            end
            RFHR_FETCH: begin
                next_state = RFHR_SHOW;
            end
            RFHR_SHOW: begin
                if (next_frame_in) begin
                    next_state = RFHR_EMPTY;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= RFHR_EMPTY;
        end else begin
            state <= next_state;
        end
    end

    // queue pointers and occupancy
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            used <= '0;
        end else begin
            if (push) begin
                wr_ptr <= step_ptr(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= step_ptr(rd_ptr);
            end
            used <= used + (ADDR_W + 1)'(push) - (ADDR_W + 1)'(pop);
        end
    end

    // head snapshot, held until the host moves on so both words match
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_view <= RFHR_WORD_RESET;
            count_view <= '0;
        end else if (state == RFHR_FETCH) begin
            status_view <= mem_bus.rd_data[RFHR_ENTRY_W-1:RFHR_COUNT_W];
            count_view <= mem_bus.rd_data[RFHR_COUNT_W-1:0];
        end else if (pop) begin
            status_view <= RFHR_WORD_RESET;
            count_view <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register reads

    wire logic showing = (state == RFHR_SHOW);
    // valid only while a whole frame and its status sit at the head
    wire logic [15:0] status_word = {showing, status_view[14:0]};
    wire logic [15:0] count_word = {4'h0, count_view};
    wire logic hit_status = (reg_addr_in == RFHR_OFS_STATUS);
    wire logic hit_count = (reg_addr_in == RFHR_OFS_COUNT);
    wire logic low_only = (reg_be_in == 2'b01);
    wire logic high_only = (reg_be_in == 2'b10);
    // in byte mode the high half comes from the copy taken at the low read
    wire logic [7:0] count_hi = high_only ? count_hi_hold : count_word[15:8];
    wire logic [15:0] count_sel = {count_hi, count_word[7:0]};
    wire logic [15:0] raw_word = hit_status ? status_word :
        (hit_count ? count_sel : 16'h0000);
    wire logic [15:0] lane_mask = {{8{reg_be_in[1]}}, {8{reg_be_in[0]}}};
    wire logic [15:0] next_rdata = raw_word & lane_mask;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_hi_hold <= 8'h00;
        end else if (reg_rd_in & hit_count & low_only) begin
            count_hi_hold <= count_word[15:8];
        end
    end

    // read data answer one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    // queue depth and a one-cycle drop pulse for the queue manager
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frames_queued_out <= '0;
            overflow_out <= 1'b0;
        end else begin
            frames_queued_out <= used + (ADDR_W + 1)'(push) - (ADDR_W + 1)'(pop);
            overflow_out <= admit & full;
        end
    end
endmodule : rfhr_core

//--- verification/rfhr_core_sva.sv
/*
 * Checker for the header reporting register port.
 * Assumes it is bound to rfhr_core and sees only its ports.
 */
module rfhr_core_sva (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // watched ports
    input wire logic frame_done_in,
    input wire logic reg_rd_in,
    input wire logic [8:0] reg_addr_in,
    input wire logic [1:0] reg_be_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic overflow_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // full-word answers, tied to the strobe one cycle back
    sequence stat_rd;
        reg_rvalid_out && $past(reg_addr_in) == 9'h17C && $past(reg_be_in) == 2'h3;
    endsequence
    sequence cnt_rd;
        reg_rvalid_out && $past(reg_addr_in) == 9'h17E && $past(reg_be_in) == 2'h3;
    endsequence
    a_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("no answer");
    a_no_stray_answer: assert property (!reg_rd_in |=> !reg_rvalid_out)
        else $error("stray");
    a_count_top_zero: assert property (cnt_rd |-> reg_rdata_out[15:12] == 4'h0)
        else $error("count top bits set");
    a_status_gaps_zero: assert property (
        stat_rd |-> (reg_rdata_out & 16'h4314) == 16'h0000)
        else $error("reserved status bit set");
    a_bcast_is_mcast: assert property (
        stat_rd ##0 reg_rdata_out[7] |-> reg_rdata_out[6])
        else $error("broadcast without multicast");
    a_ucast_not_mcast: assert property (
        stat_rd ##0 reg_rdata_out[15] |-> reg_rdata_out[5] != reg_rdata_out[6])
        else $error("unicast and multicast clash");
    a_idle_word_zero: assert property (
        stat_rd ##0 !reg_rdata_out[15] |-> reg_rdata_out == 16'h0000)
        else $error("status shown without valid");
    a_unmapped_zero: assert property (
        reg_rvalid_out && $past(reg_addr_in) != 9'h17C && $past(reg_addr_in) != 9'h17E
        |-> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_overflow_cause: assert property (overflow_out |-> $past(frame_done_in))
        else $error("overflow without frame");
    a_data_holds: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
        else $error("read data moved between reads");
endmodule : rfhr_core_sva
////////////////////////////////////////////////////////////
bind rfhr_core rfhr_core_sva u_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .frame_done_in(frame_done_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_be_in(reg_be_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .overflow_out(overflow_out));

//--- verification/rfhr_core_tb.sv
/*
 * Self-checking bench for rfhr_core: random frames, drains, overflow.
 * Assumes the package, carrier, memory and checker are compiled first.
 */
module rfhr_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_n_in = 1'b0, frame_done_in = 1'b0, pass_bad_frames_in = 1'b0;
    logic runt_in = 1'b0, crc_error_in = 1'b0, icmp_bad_in = 1'b0, ip_bad_in = 1'b0;
    logic tcp_bad_in = 1'b0, udp_bad_in = 1'b0, next_frame_in = 1'b0, reg_rd_in = 1'b0;
    logic [47:0] dest_addr_in = 48'h0;
    logic [15:0] length_type_in = 16'h0, reg_rdata_out, d;
    logic [11:0] byte_count_in = 12'h0;
    logic [8:0] reg_addr_in = 9'h0;
    logic [1:0] reg_be_in = 2'h0;
    logic [4:0] frames_queued_out;
    logic overflow_out, reg_rvalid_out;
    int errors = 0, checks = 0, cycles = 0, seed = 23364;
    logic [27:0] expq[$]; // model of the queue: status then count
    always #2.5 clk_in = ~clk_in;
    rfhr_core #(.DEPTH(16), .ADDR_W(4)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .frame_done_in(frame_done_in), .dest_addr_in(dest_addr_in),
        .length_type_in(length_type_in), .byte_count_in(byte_count_in), .runt_in(runt_in),
        .crc_error_in(crc_error_in), .icmp_bad_in(icmp_bad_in), .ip_bad_in(ip_bad_in),
        .tcp_bad_in(tcp_bad_in), .udp_bad_in(udp_bad_in),
        .pass_bad_frames_in(pass_bad_frames_in), .next_frame_in(next_frame_in),
        .frames_queued_out(frames_queued_out), .overflow_out(overflow_out),
        .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_be_in(reg_be_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // expected status; f is icmp ip tcp udp runt crc
    function automatic logic [15:0] exp_status(input logic [47:0] a, input logic [15:0] lt,
            input logic [5:0] f);
        logic [15:0] s;
        s = 16'h8000;
        s[13:10] = f[5:2];
        s[7] = (a == 48'hFFFFFFFFFFFF);
        s[6] = a[40];
        s[5] = ~a[40];
        s[3] = (lt > 16'h05DC);
        s[1:0] = f[1:0];
        return s;
    endfunction : exp_status
    // frame pulses stay high across calls so frames go back to back
    task automatic send(input logic [47:0] a, input logic [15:0] lt, input logic [11:0] n,
            input logic [5:0] f);
        @(posedge clk_in);
        dest_addr_in <= a;
        length_type_in <= lt;
        byte_count_in <= n;
        {icmp_bad_in, ip_bad_in, tcp_bad_in, udp_bad_in, runt_in, crc_error_in} <= f;
        frame_done_in <= 1'b1;
        if ((f[1:0] == 2'b00 || pass_bad_frames_in) && expq.size() < 16)
            expq.push_back({exp_status(a, lt, f), n});
    endtask : send
    task automatic batch(input int k);
        logic [31:0] r;
        logic [47:0] a;
        for (int i = 0; i < k; i++) begin
            r = $random(seed);
            a = {r[15:0], $random(seed)};
            if (r[31:30] == 2'b00) a = 48'hFFFFFFFFFFFF;
            send(a, r[29] ? 16'h05DC + {15'h0, r[28]} : r[27:12], r[23:12],
                {r[5:2], r[1:0] & {2{r[6]}}});
        end
        @(posedge clk_in);
        frame_done_in <= 1'b0;
    endtask : batch
    task automatic rd(input logic [8:0] a, input logic [1:0] be, output logic [15:0] q);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        reg_be_in <= be;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk({15'h0, reg_rvalid_out}, 16'h0001);
        q = reg_rdata_out;
    endtask : rd
    // reads each head twice around byte-lane count reads, then releases it
    task automatic drain();
        logic [27:0] e;
        while (expq.size() > 0) begin
            e = expq.pop_front();
            repeat (3) @(posedge clk_in);
            rd(9'h17C, 2'h3, d);
            chk(d, e[27:12]);
            rd(9'h17E, 2'h3, d);
            chk(d, {4'h0, e[11:0]});
            rd(9'h17E, 2'h1, d);
            chk(d, {8'h00, e[7:0]});
            rd(9'h17E, 2'h2, d);
            chk(d, {4'h0, e[11:8], 8'h00});
            rd(9'h17C, 2'h3, d);
            chk(d, e[27:12]);
            @(posedge clk_in);
            next_frame_in <= 1'b1;
            @(posedge clk_in);
            next_frame_in <= 1'b0;
        end
        repeat (3) @(posedge clk_in);
        rd(9'h17C, 2'h3, d);
        chk(d, 16'h0000);
    endtask : drain
    ////////////////////////////////////////////////////////////
    // hang guard, far above the fewer than a thousand cycles needed
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(9'h100, 2'h3, d);
        chk(d, 16'h0000);
        pass_bad_frames_in <= 1'b1;
        send(48'h010000000000, 16'h05DD, 12'hFFF, 6'h3F);
        send(48'h000000000000, 16'h05DC, 12'h000, 6'h00);
        batch(3);
        drain();
        for (int j = 0; j < 6; j++) begin
            pass_bad_frames_in <= j[0];
            batch(4);
            drain();
        end
        pass_bad_frames_in <= 1'b1;
        // a mid-run reset must drop queued frames and clear the head view
        batch(2);
        #1;
        chk({11'h0, frames_queued_out}, 16'(expq.size()));
        expq.delete();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk({11'h0, frames_queued_out}, 16'h0000);
        rd(9'h17C, 2'h3, d);
        chk(d, 16'h0000);
        batch(17);
        #1;
        chk({10'h0, overflow_out, frames_queued_out}, 16'h0030);
        drain();
        print_verdict();
    end
endmodule : rfhr_core_tb
